// >>> verilog/sacp_pkg.sv
// Shared constants and types for the serial converter port
package sacp_pkg;
    // Conversion timing (longest allowed time, rounded down)
    localparam real CONVERSION_TIME_NS = 4660.0;
    localparam real SYS_CLK_PERIOD_NS = 8.0;
    // Plain int cast rounds to nearest and would overshoot the limit by one cycle
    localparam int CONVERT_STROBE_CYCLES = int'($floor(CONVERSION_TIME_NS / SYS_CLK_PERIOD_NS)) - 1;
    // Result layout
    localparam int RESULT_BITS = 12;
    localparam int CFG_BITS = 2;
    // Configuration word bit positions (mode bit arrives first)
    localparam int CFG_MODE_POS = 1;
    localparam int CFG_POL_POS = 0;
    localparam logic [1:0] CFG_RESET = 2'h2;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // Buffer depth
    localparam int BUF_DEPTH = 2;

    typedef enum logic [3:0] {
        SACP_IDLE = 4'h1,
        SACP_CONVERT = 4'h2,
        SACP_SLEEP = 4'h4,
        SACP_SHIFT = 4'h8
    } sacp_state_t;
endpackage

// >>> verilog/sacp_buf.sv
// Two-entry valid/ready buffer for finished conversion results
`timescale 1ns/1ps
`default_nettype none
module sacp_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    initial begin
        if (DEPTH != 2) begin
            $error("sacp_buf supports depth 2 only");
        end
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = ~wp_r;
        end
        if (pop) begin
            rp_nxt = ~rp_r;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/sacp_port.sv
// Conversion sequencer and serial port of a 12-bit sampling converter
// Functional notes
// - Strobe rise starts timed conversion
// - Strobe still high at end: sleep
// - Strobe fall: sample, enable result driver
// - Result bits change on falling shift edge
// - After result, output zeros indefinitely
// - Capture 2-bit config on first rises
// - Ignore further config bits until next cycle
// - Config in, result out full duplex
// - Config sets mux for next conversion
// - Decode mode and channel into mux
// - Unipolar code, positive minus negative
// - Conversion no longer than 4.66 us
`timescale 1ns/1ps
`default_nettype none
module sacp_port
    import sacp_pkg::*;
#(
    parameter bit TWO_CHANNEL = 1'b1,
    parameter int RES_BITS = sacp_pkg::RESULT_BITS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Host pins
    input wire logic convert_strobe,
    input wire logic shift_clk,
    input wire logic serial_config_in,
    output logic serial_result_out,
    output logic serial_result_oe_b,
    // Analog front end (sampled inputs, already digital here)
    input wire logic [RES_BITS-1:0] input_channel_zero,
    input wire logic [RES_BITS-1:0] input_channel_one,
    // Mux state seen by the analog side
    output logic mux_single_ended,
    output logic mux_swap,
    output logic sleeping
);
    import sacp_pkg::*;

    initial begin
        if (RES_BITS != RESULT_BITS) begin
            $error("sacp_port result width must be 12");
        end
    end

    // ----------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------
    logic [1:0] convert_strobe_sync_r, sck_sync_r, sdi_sync_r;
    logic convert_strobe_d_r, sck_d_r;
    logic convert_strobe_s, sck_s, sdi_s;
    logic convert_strobe_rise, convert_strobe_fall, sck_rise, sck_fall;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            convert_strobe_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            sdi_sync_r <= 2'h0;
            convert_strobe_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            convert_strobe_sync_r <= {convert_strobe_sync_r[0], convert_strobe};
            sck_sync_r <= {sck_sync_r[0], shift_clk};
            sdi_sync_r <= {sdi_sync_r[0], serial_config_in};
            convert_strobe_d_r <= convert_strobe_sync_r[1];
            sck_d_r <= sck_sync_r[1];
        end
    end

    assign convert_strobe_s = convert_strobe_sync_r[1];
    assign sck_s = sck_sync_r[1];
    assign sdi_s = sdi_sync_r[1];
    assign convert_strobe_rise = convert_strobe_s && !convert_strobe_d_r;
    assign convert_strobe_fall = !convert_strobe_s && convert_strobe_d_r;
    assign sck_rise = sck_s && !sck_d_r;
    assign sck_fall = !sck_s && sck_d_r;

    // ----------------------------------------
    // Mux decode and conversion arithmetic
    // ----------------------------------------
    logic [1:0] mux_cfg_r, mux_cfg_nxt;
    logic [RES_BITS-1:0] pos_v, neg_v, code_v;

    always_comb begin
        if (!TWO_CHANNEL) begin
            pos_v = input_channel_zero;
            neg_v = input_channel_one;
        end else if (mux_cfg_r[CFG_MODE_POS]) begin
            pos_v = mux_cfg_r[CFG_POL_POS] ? input_channel_one : input_channel_zero;
            neg_v = '0;
        end else begin
            pos_v = mux_cfg_r[CFG_POL_POS] ? input_channel_one : input_channel_zero;
            neg_v = mux_cfg_r[CFG_POL_POS] ? input_channel_zero : input_channel_one;
        end
        code_v = (pos_v > neg_v) ? RES_BITS'(pos_v - neg_v) : '0;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    sacp_state_t state_r, state_nxt;
    logic [12:0] timer_r, timer_nxt;
    logic [1:0] cfg_sh_r, cfg_sh_nxt;
    logic [1:0] cfg_cnt_r, cfg_cnt_nxt;
    logic [RES_BITS-1:0] shreg_r, shreg_nxt;
    logic [4:0] bits_r, bits_nxt;
    logic sdo_r, sdo_nxt, oe_b_r, oe_b_nxt, sleep_r, sleep_nxt;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [RES_BITS-1:0] buf_out_data;

    // Finished result enters the buffer; loaded on strobe fall
    assign buf_in_valid = (state_r == SACP_CONVERT) && (timer_r == 13'h0000);
    assign buf_out_ready = convert_strobe_fall;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        cfg_sh_nxt = cfg_sh_r;
        cfg_cnt_nxt = cfg_cnt_r;
        mux_cfg_nxt = mux_cfg_r;
        shreg_nxt = shreg_r;
        bits_nxt = bits_r;
        sdo_nxt = sdo_r;
        oe_b_nxt = oe_b_r;
        sleep_nxt = 1'b0;
        case (state_r)
            SACP_IDLE: begin
                if (convert_strobe_rise) begin
                    state_nxt = SACP_CONVERT;
                    timer_nxt = 13'(CONVERT_STROBE_CYCLES);
                end
            end
            SACP_CONVERT: begin
                oe_b_nxt = 1'b1;
                if (timer_r != 13'h0000) begin
                    timer_nxt = timer_r - 13'h0001;
                // bounded time, stall if buffer full
                end else if (buf_in_ready) begin
                    state_nxt = SACP_SLEEP;
                end
            end
            SACP_SLEEP: begin
                sleep_nxt = convert_strobe_s;
                if (convert_strobe_fall && buf_out_valid) begin
                    state_nxt = SACP_SHIFT;
                    oe_b_nxt = 1'b0;
                    shreg_nxt = {buf_out_data[RES_BITS-2:0], 1'b0};
                    sdo_nxt = buf_out_data[RES_BITS-1];
                    bits_nxt = 5'(RES_BITS - 1);
                    cfg_cnt_nxt = 2'h0;
                    sleep_nxt = 1'b0;
                end
            end
            SACP_SHIFT: begin
                // change on falling edge, zeros after last bit
                if (sck_fall) begin
                    sdo_nxt = (bits_r != 5'h00) ? shreg_r[RES_BITS-1] : 1'b0;
                    shreg_nxt = {shreg_r[RES_BITS-2:0], 1'b0};
                    if (bits_r != 5'h00) begin
                        bits_nxt = bits_r - 5'h01;
                    end
                end
                // capture config, same clock as result
                if (TWO_CHANNEL && sck_rise && cfg_cnt_r != 2'(CFG_BITS)) begin
                    cfg_sh_nxt = {cfg_sh_r[0], sdi_s};
                    cfg_cnt_nxt = cfg_cnt_r + 2'h1;
                    if (cfg_cnt_r == 2'h1) begin
                        mux_cfg_nxt = {cfg_sh_r[0], sdi_s};
                    end
                end
                // later bits ignored by the count guard
                if (convert_strobe_rise) begin
                    oe_b_nxt = 1'b1;
                    state_nxt = SACP_CONVERT;
                    timer_nxt = 13'(CONVERT_STROBE_CYCLES);
                end
            end
            default: begin
                state_nxt = SACP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SACP_IDLE;
            timer_r <= 13'h0000;
            cfg_sh_r <= 2'h0;
            cfg_cnt_r <= 2'h0;
            mux_cfg_r <= CFG_RESET;
            shreg_r <= RESULT_RESET;
            bits_r <= 5'h00;
            sdo_r <= 1'b0;
            oe_b_r <= 1'b1;
            sleep_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
            cfg_sh_r <= cfg_sh_nxt;
            cfg_cnt_r <= cfg_cnt_nxt;
            mux_cfg_r <= mux_cfg_nxt;
            shreg_r <= shreg_nxt;
            bits_r <= bits_nxt;
            sdo_r <= sdo_nxt;
            oe_b_r <= oe_b_nxt;
            sleep_r <= sleep_nxt;
        end
    end

    // ----------------------------------------
    // Result buffer
    // ----------------------------------------
    // Holds finished codes so a late strobe fall never loses a word
    sacp_buf #(
        .WIDTH(RES_BITS),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(code_v),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    assign serial_result_out = sdo_r;
    assign serial_result_oe_b = oe_b_r;
    assign mux_single_ended = mux_cfg_r[CFG_MODE_POS];
    assign mux_swap = mux_cfg_r[CFG_POL_POS];
    assign sleeping = sleep_r;
endmodule
`default_nettype wire

// >>> test/sacp_port_sva.sv
// Pin-level checker for the serial converter port
`timescale 1ns/1ps
`default_nettype none
module sacp_port_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Pins
    input wire logic convert_strobe,
    input wire logic shift_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe_b,
    input wire logic mux_single_ended,
    input wire logic mux_swap,
    input wire logic sleeping
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_convert_strobe_time_sleep: assert property ($rose(convert_strobe) |-> ##300 !sleeping ##[270:300] sleeping)
        else $error("sleep off time");
    a_sleep_hold: assert property (sleeping && convert_strobe |=> sleeping)
        else $error("sleep left early");
    a_sleep_exit: assert property (sleeping && !convert_strobe |-> ##[1:5] !sleeping)
        else $error("sleep kept");
    a_oe_enable: assert property ($fell(convert_strobe) && sleeping |-> ##[1:6] !serial_result_oe_b)
        else $error("driver not on");
    a_oe_release: assert property ($rose(convert_strobe) |-> ##[1:6] serial_result_oe_b)
        else $error("driver not off");
    a_oe_hold: assert property (!serial_result_oe_b && !convert_strobe |=> !serial_result_oe_b)
        else $error("driver dropped");
    // Result may move only a few cycles after a shift fall
    a_sdo_on_fall: assert property ($changed(serial_result_out) && !serial_result_oe_b &&
        !$past(serial_result_oe_b) |-> !$past(shift_clk, 2)) else $error("result moved off fall");
    a_mux_on_rise: assert property ($changed({mux_single_ended, mux_swap}) |->
        !$past(convert_strobe, 4) && $past(shift_clk, 2)) else $error("mux moved off rise");
endmodule
`default_nettype wire

// >>> test/sacp_host.sv
// Host model: drives strobe, shift clock and config word
`timescale 1ns/1ps
`default_nettype none
module sacp_host (
    // Clock
    input wire logic sys_clk,
    // Pins
    output logic convert_strobe,
    output logic shift_clk,
    output logic serial_config_in,
    input wire logic serial_result_out
);
    initial begin
        convert_strobe = 1'b0;
        shift_clk = 1'b0;
        serial_config_in = 1'b0;
    end
    task automatic convert();
        @(posedge sys_clk) convert_strobe <= 1'b1;
        repeat (600) @(posedge sys_clk);
    endtask
    task automatic frame(input logic [3:0] cfg, output logic [15:0] got);
        int i;
        @(posedge sys_clk) convert_strobe <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (i = 0; i < 16; i++) begin
            shift_clk <= 1'b0;
            // Spent config line toggles so stale bits never look valid
            serial_config_in <= (i < 4) ? cfg[3 - i] : ~serial_config_in;
            repeat (3) @(posedge sys_clk);
            @(negedge sys_clk) got[15 - i] = serial_result_out;
            @(posedge sys_clk) shift_clk <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
        shift_clk <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// >>> test/sacp_port_tb.sv
// Self-checking bench for the serial converter port
`timescale 1ns/1ps
`default_nettype none
module sacp_port_tb;
    import sacp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic convert_strobe, shift_clk, serial_config_in, serial_result_out;
    logic serial_result_oe_b, mux_single_ended, mux_swap, sleeping;
    logic [11:0] ch0 = 12'h000;
    logic [11:0] ch1 = 12'h000;
    logic [1:0] mux_now = CFG_RESET;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 9;
    int k;
    always #4 sys_clk = ~sys_clk;
    sacp_port u_sacp_port (.sys_clk(sys_clk), .rst_b(rst_b), .convert_strobe(convert_strobe),
        .shift_clk(shift_clk), .serial_config_in(serial_config_in), .serial_result_out(serial_result_out),
        .serial_result_oe_b(serial_result_oe_b), .input_channel_zero(ch0), .input_channel_one(ch1),
        .mux_single_ended(mux_single_ended), .mux_swap(mux_swap), .sleeping(sleeping));
    sacp_host u_sacp_host (.sys_clk(sys_clk), .convert_strobe(convert_strobe), .shift_clk(shift_clk),
        .serial_config_in(serial_config_in), .serial_result_out(serial_result_out));
    function automatic logic [11:0] code(input logic [1:0] c, input logic [11:0] a, input logic [11:0] b);
        logic [11:0] p;
        logic [11:0] n;
        p = c[0] ? b : a;
        n = c[1] ? 12'h000 : (c[0] ? a : b);
        return (p > n) ? p - n : 12'h000;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Code comes from the mux set in the frame before
    task automatic run(input logic [3:0] cfg, input logic [11:0] a, input logic [11:0] b);
        logic [15:0] got;
        @(posedge sys_clk);
        ch0 <= a;
        ch1 <= b;
        u_sacp_host.convert();
        check("sleeping", {15'h0000, sleeping}, 16'h0001);
        u_sacp_host.frame(cfg, got);
        check("result", got, {code(mux_now, a, b), 4'h0});
        check("mux", {14'h0000, mux_single_ended, mux_swap}, {14'h0000, cfg[3:2]});
        mux_now = cfg[3:2];
        $display("frame cfg %h done", cfg);
    endtask
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 15000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        check("reset", {12'h000, serial_result_oe_b, sleeping, mux_single_ended, mux_swap},
            {12'h000, 1'b1, 1'b0, CFG_RESET});
        for (k = 0; k < 5; k++) begin
            run({k[1:0], 2'h3}, 12'hFFF, 12'h000);
        end
        run(4'h0, 12'h5A5, 12'h5A5);
        for (k = 0; k < 7; k++) begin
            run(4'($random(seed)), 12'($random(seed)), 12'($random(seed)));
        end
        finish_test();
    end
endmodule
bind sacp_port sacp_port_sva u_sacp_port_sva (.sys_clk(sys_clk), .rst_b(rst_b),
    .convert_strobe(convert_strobe), .shift_clk(shift_clk), .serial_result_out(serial_result_out),
    .serial_result_oe_b(serial_result_oe_b), .mux_single_ended(mux_single_ended),
    .mux_swap(mux_swap), .sleeping(sleeping));
`default_nettype wire
